/* File: rtl/drive_safety_seq.sv */
// Drive safety interlock sequencer: stop-function interaction, restart window,
// password, duplicated parameter checking and test-stop monitoring.
// Assumes controller selections and commands arrive asynchronously on pins.
`timescale 1ns/1ps
module drive_safety_seq
    import drive_safety_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DFLT,
    parameter int AW = 4,
    parameter int DW = 16,
    parameter int TW = 32
) (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_SRST,
    // Selections, commands and speed feedback (asynchronous)
    input wire sel_t I_SEL,
    input wire cmd_t I_CMD,
    input wire logic I_STANDSTILL,
    input wire logic I_OVER_LIMIT,
    input wire logic [3:0] I_TEST_SRC,
    // Test configuration
    input wire logic [1:0] I_EXT_TRIG_SEL,
    input wire logic [TW-1:0] I_BASIC_INTERVAL,
    input wire logic [TW-1:0] I_EXT_INTERVAL,
    // Password and parameter access
    input wire logic I_PWD_ENTER,
    input wire logic I_PWD_CHANGE,
    input wire logic I_PWD_LOCK,
    input wire logic [31:0] I_PWD_VALUE,
    input wire logic I_PAR_WR,
    input wire logic [1:0] I_PAR_COPY,
    input wire logic [AW-1:0] I_PAR_ADDR,
    input wire logic [DW-1:0] I_PAR_DATA,
    input wire logic I_COMMISSIONED,
    // Drive control
    output logic O_TORQUE_EN,
    output ramp_t O_RAMP,
    output logic O_SPEED_LIMIT_EN,
    output state_t O_STATE,
    // Test and status
    output logic O_BASIC_TEST,
    output logic O_EXT_TEST,
    output logic [TW-1:0] O_BASIC_TIME_LEFT,
    output logic [TW-1:0] O_EXT_TIME_LEFT,
    output logic [31:0] O_STATUS,
    output logic O_UNLOCKED,
    output logic O_PWD_REJECT,
    output logic O_PARAM_FAULT
);
    localparam int SW = 13;
    localparam logic [TW-1:0] WIN_LOAD = TW'(RESTART_WINDOW_TICKS);

    // Two-stage synchroniser for selection, command, speed feedback and test-source inputs
    logic [SW-1:0] sync1_reg, sync2_reg;
    always_ff @(posedge I_REF_CLK) begin
        sync1_reg <= {I_SEL, I_CMD, I_STANDSTILL, I_OVER_LIMIT, I_TEST_SRC};
        sync2_reg <= sync1_reg;
    end

    sel_t sel;
    cmd_t cmd;
    logic standstill, over_limit;
    logic [3:0] test_src;
    assign {sel, cmd, standstill, over_limit, test_src} = sync2_reg;

    // One-second tick prescaler
    logic [31:0] pre_reg, pre_next;
    logic tick;
    assign tick = (pre_reg == 32'(TICK_CYCLES - 1));
    always_comb begin
        pre_next = tick ? 32'h0 : pre_reg + 32'h1;
    end
    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            pre_reg <= 32'h0;
        end else begin
            pre_reg <= pre_next;
        end
    end

    // Edge history
    logic tc_prev_reg, src_prev_reg, por_reg;
    logic tc_rise, tc_fall, src_sel, ext_start;
    assign src_sel = test_src[I_EXT_TRIG_SEL];
    assign tc_rise = sel.torque_cutoff && !tc_prev_reg;
    assign tc_fall = !sel.torque_cutoff && tc_prev_reg;
    assign ext_start = src_sel && !src_prev_reg;
    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            tc_prev_reg <= 1'b0;
            src_prev_reg <= 1'b0;
            por_reg <= 1'b1;
        end else begin
            tc_prev_reg <= sel.torque_cutoff;
            src_prev_reg <= src_sel;
            por_reg <= 1'b0;
        end
    end

    // Sequencer state
    state_t state_reg, state_next;
    ramp_t ramp_reg, ramp_next;
    logic stop_seen_reg, stop_seen_next;
    logic [TW-1:0] win_reg, win_next;
    logic braking, torque_off;
    assign braking = (state_reg == ST_CSTOP) || (state_reg == ST_LSTOP);
    assign torque_off = !(braking || state_reg == ST_RUN);

    always_comb begin
        state_next = state_reg;
        ramp_next = ramp_reg;
        case (state_reg)
            ST_IDLE: begin
                if (sel.torque_cutoff) begin
                    state_next = ST_CUTOFF;
                end else if (sel.limited_speed) begin
                    state_next = ST_WINDOW;
                end else if (cmd.run && !sel.controlled_stop) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (sel.torque_cutoff || cmd.coast_stop_cmd) begin
                    state_next = ST_CUTOFF;
                end else if (sel.controlled_stop) begin
                    state_next = ST_CSTOP;
                    ramp_next = RAMP_QUICK;
                end else if (cmd.quick_stop_cmd) begin
                    state_next = ST_LSTOP;
                    ramp_next = RAMP_QUICK;
                end else if (cmd.ramp_stop_cmd) begin
                    state_next = ST_LSTOP;
                    ramp_next = RAMP_NORMAL;
                end
            end
            ST_CSTOP: begin
                // Ramp-stop and quick-stop leave the quick ramp untouched; coast-stop cuts torque
                if (sel.torque_cutoff || cmd.coast_stop_cmd || standstill) begin
                    state_next = ST_CUTOFF;
                end
            end
            ST_LSTOP: begin
                if (sel.torque_cutoff || cmd.coast_stop_cmd || standstill) begin
                    state_next = ST_CUTOFF;
                end else if (sel.limited_speed && over_limit) begin
                    state_next = ST_CUTOFF;
                end
            end
            ST_CUTOFF: begin
                if (!sel.torque_cutoff && !sel.controlled_stop && stop_seen_reg) begin
                    state_next = sel.limited_speed ? ST_WINDOW : ST_IDLE;
                end
            end
            ST_WINDOW: begin
                if (sel.torque_cutoff || sel.controlled_stop) begin
                    state_next = ST_CUTOFF;
                end else if (!sel.limited_speed) begin
                    state_next = ST_IDLE;
                end else if (cmd.run && win_reg != '0) begin
                    state_next = ST_RUN;
                end else if (win_reg == '0) begin
                    state_next = ST_LOCK;
                end
            end
            ST_LOCK: begin
                // Run ignored until cutoff has been selected and released
                if (tc_fall) begin
                    state_next = ST_WINDOW;
                end
            end
            default: begin
                state_next = ST_CUTOFF;
            end
        endcase
        if (state_next == ST_RUN) begin
            ramp_next = RAMP_NONE;
        end
        // A ramp-stop while torque is off is remembered until the next run
        stop_seen_next = stop_seen_reg;
        if (state_next == ST_RUN) begin
            stop_seen_next = 1'b0;
        end
        if (torque_off && cmd.ramp_stop_cmd) begin
            stop_seen_next = 1'b1;
        end
        win_next = win_reg;
        if (state_next == ST_WINDOW && state_reg != ST_WINDOW) begin
            win_next = WIN_LOAD;
        end else if (tick && win_reg != '0) begin
            win_next = win_reg - TW'(1);
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            state_reg <= ST_CUTOFF;
            ramp_reg <= RAMP_NONE;
            stop_seen_reg <= 1'b0;
            win_reg <= '0;
        end else begin
            state_reg <= state_next;
            ramp_reg <= ramp_next;
            stop_seen_reg <= stop_seen_next;
            win_reg <= win_next;
        end
    end

    assign O_STATE = state_reg;
    assign O_TORQUE_EN = !torque_off;
    assign O_RAMP = braking ? ramp_reg : RAMP_NONE;
    assign O_SPEED_LIMIT_EN = sel.limited_speed && !torque_off;

    // Test-stop monitoring: channel 0 basic, channel 1 extended
    logic [1:0] test_now;
    logic [1:0] alarm;
    logic [TW-1:0] interval [2];
    logic [TW-1:0] left_reg [2];
    logic [TW-1:0] left_next [2];
    logic btest_reg, etest_reg;
    assign test_now[1] = ext_start;
    assign test_now[0] = por_reg || tc_rise || ext_start;
    assign interval[0] = I_BASIC_INTERVAL;
    assign interval[1] = I_EXT_INTERVAL;

    for (genvar ch = 0; ch < 2; ch++) begin : g_test
        always_comb begin
            left_next[ch] = left_reg[ch];
            if (test_now[ch]) begin
                left_next[ch] = interval[ch];
            end else if (tick && left_reg[ch] != '0) begin
                left_next[ch] = left_reg[ch] - TW'(1);
            end
        end
        always_ff @(posedge I_REF_CLK) begin
            if (I_SRST) begin
                left_reg[ch] <= '0;
            end else begin
                left_reg[ch] <= left_next[ch];
            end
        end
        // Alarm only reports; sequencer is not affected
        assign alarm[ch] = (left_reg[ch] == '0);
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            btest_reg <= 1'b0;
            etest_reg <= 1'b0;
        end else begin
            btest_reg <= test_now[0];
            etest_reg <= test_now[1];
        end
    end
    assign O_BASIC_TEST = btest_reg;
    assign O_EXT_TEST = etest_reg;
    assign O_BASIC_TIME_LEFT = left_reg[0];
    assign O_EXT_TIME_LEFT = left_reg[1];

    // Password
    logic [31:0] pwd_reg, pwd_next;
    logic unl_reg, unl_next, rej_reg, rej_next;
    always_comb begin
        pwd_next = pwd_reg;
        unl_next = unl_reg;
        rej_next = 1'b0;
        if (I_PWD_LOCK) begin
            unl_next = 1'b0;
        end else if (I_PWD_ENTER) begin
            unl_next = (I_PWD_VALUE == pwd_reg);
            rej_next = (I_PWD_VALUE != pwd_reg);
        end else if (I_PWD_CHANGE) begin
            if (unl_reg && I_PWD_VALUE != FACTORY_PASSWORD) begin
                pwd_next = I_PWD_VALUE;
            end else begin
                rej_next = 1'b1;
            end
        end
    end
    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            pwd_reg <= FACTORY_PASSWORD;
            unl_reg <= 1'b0;
            rej_reg <= 1'b0;
        end else begin
            pwd_reg <= pwd_next;
            unl_reg <= unl_next;
            rej_reg <= rej_next;
        end
    end
    assign O_UNLOCKED = unl_reg;
    assign O_PWD_REJECT = rej_reg;

    // Duplicated parameters and continuous checksum scan
    logic [DW-1:0] rd_a, rd_b;
    logic [AW-1:0] scan_reg, scan_next, rda_reg;
    logic rdv_reg, ref_ok_reg, ref_ok_next, flt_reg, flt_next;
    logic [15:0] crc_reg, crc_next, ref_reg, ref_next, crc_word;

    safety_param_store #(.AW(AW), .DW(DW)) u_store (
        .i_clk(I_REF_CLK),
        .i_wr(I_PAR_WR && unl_reg && !I_COMMISSIONED),
        .i_wr_copy(I_PAR_COPY),
        .i_wr_addr(I_PAR_ADDR),
        .i_wr_data(I_PAR_DATA),
        .i_rd_addr(scan_reg),
        .o_rd_a(rd_a),
        .o_rd_b(rd_b)
    );

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [DW-1:0] d);
        logic [15:0] r;
        r = c;
        for (int k = DW - 1; k >= 0; k--) begin
            r = (r[15] ^ d[k]) ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
        end
        return r;
    endfunction : crc_step

    assign crc_word = crc_step(crc_reg, rd_a);
    always_comb begin
        scan_next = scan_reg + AW'(1);
        crc_next = crc_reg;
        ref_next = ref_reg;
        ref_ok_next = ref_ok_reg;
        flt_next = flt_reg;
        if (!I_COMMISSIONED) begin
            // Scan restarts at word 0 so the first reference covers every word
            scan_next = '0;
            crc_next = CRC_INIT;
            ref_ok_next = 1'b0;
            flt_next = 1'b0;
        end else if (rdv_reg) begin
            crc_next = crc_word;
            if (rd_a != rd_b) begin
                flt_next = 1'b1;
            end
            if (rda_reg == '1) begin
                crc_next = CRC_INIT;
                ref_next = crc_word;
                ref_ok_next = 1'b1;
                if (ref_ok_reg && crc_word != ref_reg) begin
                    flt_next = 1'b1;
                end
            end
        end
    end
    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            scan_reg <= '0;
            rda_reg <= '0;
            rdv_reg <= 1'b0;
            crc_reg <= CRC_INIT;
            ref_reg <= CRC_INIT;
            ref_ok_reg <= 1'b0;
            flt_reg <= 1'b0;
        end else begin
            scan_reg <= scan_next;
            rda_reg <= scan_reg;
            rdv_reg <= I_COMMISSIONED;
            crc_reg <= crc_next;
            ref_reg <= ref_next;
            ref_ok_reg <= ref_ok_next;
            flt_reg <= flt_next;
        end
    end
    assign O_PARAM_FAULT = flt_reg;

    // Status word
    always_comb begin
        O_STATUS = 32'h0;
        O_STATUS[STAT_TORQUE_OFF_BIT] = torque_off;
        O_STATUS[EXT_ALARM_BIT] = alarm[1];
        O_STATUS[STAT_LOAD_MON_BIT] = sel.limited_speed && !torque_off;
        O_STATUS[STAT_PARAM_FAULT_BIT] = flt_reg;
        O_STATUS[BASIC_ALARM_BIT] = alarm[0];
    end

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_SRST);

    chk_cutoff_now: assert property (!torque_off && sel.torque_cutoff |=> !O_TORQUE_EN)
        else $error("torque not removed after cutoff");
    chk_cstop_quick: assert property (state_reg == ST_CSTOP |-> O_RAMP == RAMP_QUICK)
        else $error("controlled stop not on quick ramp");
    chk_cstop_holds: assert property (state_reg == ST_CSTOP && !sel.torque_cutoff
        && !cmd.coast_stop_cmd && !standstill |=> state_reg == ST_CSTOP)
        else $error("stop command disturbed controlled stop");
    chk_coast_cstop: assert property (state_reg == ST_CSTOP && cmd.coast_stop_cmd
        |=> state_reg == ST_CUTOFF)
        else $error("coast stop ignored in controlled stop");
    chk_coast_limit: assert property (state_reg == ST_RUN && sel.limited_speed
        && cmd.coast_stop_cmd |=> torque_off)
        else $error("coast stop ignored under limit");
    chk_window_load: assert property (state_reg != ST_WINDOW && state_next == ST_WINDOW
        |=> win_reg == WIN_LOAD)
        else $error("restart window not loaded");
    chk_lock_ignores: assert property (state_reg == ST_LOCK && !tc_fall
        |=> state_reg == ST_LOCK && !O_TORQUE_EN)
        else $error("run accepted while locked");
    chk_pwd_zero: assert property (I_PWD_CHANGE && !I_PWD_ENTER && !I_PWD_LOCK
        && I_PWD_VALUE == FACTORY_PASSWORD |=> $stable(pwd_reg) && O_PWD_REJECT)
        else $error("zero password accepted");
    chk_cutoff_test: assert property (tc_rise |=> O_BASIC_TEST)
        else $error("no circuit test after cutoff");
    chk_ext_both: assert property (O_EXT_TEST |-> O_BASIC_TEST)
        else $error("extended test skipped basic circuits");
    chk_alarm_expiry: assert property (left_reg[0] == TW'(1) && tick && !test_now[0]
        |=> O_STATUS[BASIC_ALARM_BIT])
        else $error("basic alarm missing at expiry");
endmodule : drive_safety_seq

/* File: rtl/drive_safety_pkg.sv */
// Constants, carriers and state codes for the drive safety interlock sequencer.
// Assumes a single 100 MHz system clock and a synchronous power-on reset.
// Summary of operation
// - Torque cutoff during controlled stop removes torque at once; motor coasts.
// - Torque cutoff during limited speed removes torque at once.
// - Restart with limit: ramp-stop, deselect cutoff, run within five seconds.
// - Controlled stop under limit brakes on quick ramp, cuts torque at standstill.
// - Ramp-stop or quick-stop during controlled stop changes nothing.
// - Coast-stop during controlled stop cuts torque at once.
// - Ramp or quick stop under limit brakes on matching ramp, checks limit.
// - Coast-stop during limited speed cuts torque at once.
// - Window expiry enters lock state; late run ignored until cutoff cycled.
// - Parameter changes need 32-bit password, factory zero, user range 1..all ones.
// - Parameters held twice and continuously checked by checksums after commissioning.
// - Torque-removal circuits tested at power-on, each cutoff selection, each extended test.
// - Extended test starts on selectable trigger and tests both circuit groups.
// - Two readable countdowns give remaining extended and basic test time.
// - Countdown expiry raises matching alarm without stopping the drive.
// - Basic alarm on status bit 31, extended alarm on status bit 1.
// - Status shows whether load speed monitoring runs under limited speed.
package drive_safety_pkg;

    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_PERIOD_S = 1;
    localparam int TICK_CYCLES_DFLT = CLK_HZ * TICK_PERIOD_S;
    localparam int RESTART_WINDOW_S = 5;
    localparam int RESTART_WINDOW_TICKS = RESTART_WINDOW_S / TICK_PERIOD_S;

    localparam logic [31:0] FACTORY_PASSWORD = 32'h0000_0000;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hffff;

    // Status word layout
    localparam int STAT_TORQUE_OFF_BIT = 0;
    localparam int EXT_ALARM_BIT = 1;
    localparam int STAT_LOAD_MON_BIT = 4;
    localparam int STAT_PARAM_FAULT_BIT = 8;
    localparam int BASIC_ALARM_BIT = 31;

    typedef struct packed {
        logic torque_cutoff;
        logic controlled_stop;
        logic limited_speed;
    } sel_t;

    typedef struct packed {
        logic run;
        logic ramp_stop_cmd;
        logic coast_stop_cmd;
        logic quick_stop_cmd;
    } cmd_t;

    typedef enum logic [1:0] {
        RAMP_NONE = 2'h0,
        RAMP_NORMAL = 2'h1,
        RAMP_QUICK = 2'h2
    } ramp_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_RUN = 7'h02,
        ST_CSTOP = 7'h04,
        ST_LSTOP = 7'h08,
        ST_CUTOFF = 7'h10,
        ST_WINDOW = 7'h20,
        ST_LOCK = 7'h40
    } state_t;

endpackage : drive_safety_pkg

/* File: rtl/safety_param_store.sv */
// Duplicated safety parameter memory: two copies, registered read data.
// Assumes writes and reads are on the same clock as the sequencer.
`timescale 1ns/1ps
module safety_param_store #(
    parameter int AW = 4,
    parameter int DW = 16
) (
    // Clock (no reset)
    input wire logic i_clk,
    // Write port
    input wire logic i_wr,
    input wire logic [1:0] i_wr_copy,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [DW-1:0] i_wr_data,
    // Read port
    input wire logic [AW-1:0] i_rd_addr,
    output logic [DW-1:0] o_rd_a,
    output logic [DW-1:0] o_rd_b
);
    logic [DW-1:0] copy_a [2**AW];
    logic [DW-1:0] copy_b [2**AW];

    always_ff @(posedge i_clk) begin
        if (i_wr && i_wr_copy[0]) begin
            copy_a[i_wr_addr] <= i_wr_data;
        end
        if (i_wr && i_wr_copy[1]) begin
            copy_b[i_wr_addr] <= i_wr_data;
        end
        o_rd_a <= copy_a[i_rd_addr];
        o_rd_b <= copy_b[i_rd_addr];
    end
endmodule : safety_param_store

/* File: verification/ctl_model.sv */
// Controller model: drives selections, commands and test intervals.
// Assumes the bench calls its tasks; pins change on falling edges only.
`timescale 1ns/1ps
module ctl_model
    import drive_safety_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Towards the device
    output sel_t o_sel,
    output cmd_t o_cmd,
    output logic [31:0] o_interval
);
    initial begin
        o_sel = '0;
        o_cmd = '0;
    end
    // One value feeds both monitoring intervals
    task automatic set_interval(input logic [31:0] t);
        @(negedge i_clk);
        o_interval = t;
    endtask : set_interval
    task automatic set_sel(input sel_t s);
        @(negedge i_clk);
        o_sel = s;
        repeat (6) @(negedge i_clk);
    endtask : set_sel
    task automatic pulse(input cmd_t c);
        @(negedge i_clk);
        o_cmd = c;
        repeat (6) @(negedge i_clk);
        o_cmd = '0;
        repeat (6) @(negedge i_clk);
    endtask : pulse
    // Ramp-stop, new selection, then run inside the window
    task automatic restart(input sel_t s);
        pulse(4'h4);
        set_sel(s);
        pulse(4'h8);
    endtask : restart
endmodule : ctl_model

/* File: verification/drive_safety_seq_test.sv */
// Self-checking bench for the drive safety sequencer with a reference model.
// Assumes the controller model drives selections and commands.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module drive_safety_seq_test;
    import drive_safety_pkg::*;
    logic clk, srst, standstill, over_limit, par_wr, commissioned;
    logic [3:0] test_src, par_addr;
    logic [1:0] trig_sel, par_copy;
    logic [2:0] pwd_op;
    logic [31:0] pwd_value;
    logic [15:0] par_data;
    sel_t sel;
    cmd_t cmd;
    ramp_t ramp;
    state_t state;
    logic torque_en, basic_test, ext_test, unlocked, pwd_rej, par_fault, lim_en;
    logic [31:0] interval, basic_left, ext_left, status, v;
    logic [31:0] pwd_m = 32'h0;
    logic unl_m = 1'b0;
    logic [15:0] mem [16];
    int n_mismatch = 0;
    int compares = 0;
    int n_basic = 0;
    int n_ext = 0;
    int nb;

    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (basic_test === 1'b1) n_basic++;
        if (ext_test === 1'b1) n_ext++;
    end

    ctl_model ctl_model_i (.i_clk(clk), .o_sel(sel), .o_cmd(cmd), .o_interval(interval));
    drive_safety_seq #(.TICK_CYCLES(10)) drive_safety_seq_i (
        .I_REF_CLK(clk), .I_SRST(srst), .I_SEL(sel), .I_CMD(cmd),
        .I_STANDSTILL(standstill), .I_OVER_LIMIT(over_limit), .I_TEST_SRC(test_src),
        .I_EXT_TRIG_SEL(trig_sel), .I_BASIC_INTERVAL(interval), .I_EXT_INTERVAL(interval),
        .I_PWD_ENTER(pwd_op[1]), .I_PWD_CHANGE(pwd_op[0]), .I_PWD_LOCK(pwd_op[2]),
        .I_PWD_VALUE(pwd_value), .I_PAR_WR(par_wr), .I_PAR_COPY(par_copy),
        .I_PAR_ADDR(par_addr), .I_PAR_DATA(par_data), .I_COMMISSIONED(commissioned),
        .O_TORQUE_EN(torque_en), .O_RAMP(ramp), .O_SPEED_LIMIT_EN(lim_en), .O_STATE(state),
        .O_BASIC_TEST(basic_test), .O_EXT_TEST(ext_test), .O_BASIC_TIME_LEFT(basic_left),
        .O_EXT_TIME_LEFT(ext_left), .O_STATUS(status), .O_UNLOCKED(unlocked),
        .O_PWD_REJECT(pwd_rej), .O_PARAM_FAULT(par_fault));

    task automatic summarize;
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    task automatic expect_st(input state_t s, input ramp_t r);
        `CHK(state, s)
        `CHK(torque_en, s inside {ST_RUN, ST_CSTOP, ST_LSTOP})
        `CHK(ramp, r)
        `CHK(lim_en, (s inside {ST_RUN, ST_CSTOP, ST_LSTOP}) && sel.limited_speed)
    endtask : expect_st

    // Password model: lock, enter, change in that priority
    task automatic pwd(input logic [2:0] op, input logic [31:0] val);
        logic rej;
        rej = 1'b0;
        if (op[2])
            unl_m = 1'b0;
        else if (op[1]) begin
            unl_m = (val == pwd_m);
            rej = !unl_m;
        end else begin
            rej = !unl_m || val == 32'h0;
            if (!rej)
                pwd_m = val;
        end
        @(negedge clk);
        pwd_op = op;
        pwd_value = val;
        @(negedge clk);
        pwd_op = 3'h0;
        if (!op[2])
            `CHK(pwd_rej, rej)
        `CHK(unlocked, unl_m)
    endtask : pwd

    task automatic par(input logic [1:0] cp, input logic [3:0] a, input logic [15:0] d);
        @(negedge clk);
        par_wr = 1'b1;
        par_copy = cp;
        par_addr = a;
        par_data = d;
        @(negedge clk);
        par_wr = 1'b0;
    endtask : par

    initial begin
        clk = 1'b0;
        srst = 1'b1;
        {standstill, over_limit, test_src, pwd_op, pwd_value} = '0;
        {par_wr, par_copy, par_addr, par_data, commissioned} = '0;
        void'($urandom(37));
        trig_sel = 2'($urandom_range(3));
        v = $urandom | 32'h1;
        for (int a = 0; a < 16; a++)
            mem[a] = 16'($urandom);
        ctl_model_i.set_interval(32'(8 + $urandom_range(3)));
        repeat (15) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        expect_st(ST_CUTOFF, RAMP_NONE);
        `CHK(status[31], 1'b0)
        `CHK(status[1], 1'b1)
        `CHK(n_basic, 1)
        pwd(3'h2, 32'h0);
        pwd(3'h1, 32'h0);
        pwd(3'h1, v);
        pwd(3'h4, v);
        pwd(3'h2, 32'h0);
        pwd(3'h1, v);
        pwd(3'h2, v);
        for (int a = 0; a < 16; a++)
            par(2'h3, 4'(a), mem[a]);
        commissioned = 1'b1;
        repeat (60) @(negedge clk);
        `CHK(par_fault, 1'b0)
        commissioned = 1'b0;
        par(2'h1, 4'h5, mem[5] ^ 16'h0001);
        commissioned = 1'b1;
        repeat (60) @(negedge clk);
        `CHK(par_fault, 1'b1)
        commissioned = 1'b0;
        ctl_model_i.restart(3'h0);
        expect_st(ST_RUN, RAMP_NONE);
        for (int k = 0; k < 2; k++) begin
            ctl_model_i.set_sel(3'h2);
            expect_st(ST_CSTOP, RAMP_QUICK);
            ctl_model_i.pulse(k ? 4'h1 : 4'h4);
            expect_st(ST_CSTOP, RAMP_QUICK);
            nb = n_basic;
            if (k == 0)
                ctl_model_i.set_sel(3'h6);
            else
                ctl_model_i.pulse(4'h2);
            expect_st(ST_CUTOFF, RAMP_NONE);
            `CHK(n_basic, nb + 1 - k)
            ctl_model_i.restart(3'h0);
            expect_st(ST_RUN, RAMP_NONE);
        end
        ctl_model_i.set_sel(3'h1);
        expect_st(ST_RUN, RAMP_NONE);
        `CHK(status[4], 1'b1)
        ctl_model_i.set_sel(3'h5);
        expect_st(ST_CUTOFF, RAMP_NONE);
        ctl_model_i.restart(3'h1);
        expect_st(ST_RUN, RAMP_NONE);
        for (int j = 0; j < 2; j++) begin
            ctl_model_i.pulse(j ? 4'h1 : 4'h4);
            expect_st(ST_LSTOP, j ? RAMP_QUICK : RAMP_NORMAL);
            over_limit = (j == 0);
            standstill = (j == 1);
            repeat (6) @(negedge clk);
            expect_st(ST_CUTOFF, RAMP_NONE);
            over_limit = 1'b0;
            standstill = 1'b0;
            ctl_model_i.restart(3'h1);
            expect_st(ST_RUN, RAMP_NONE);
        end
        ctl_model_i.set_sel(3'h3);
        expect_st(ST_CSTOP, RAMP_QUICK);
        standstill = 1'b1;
        repeat (6) @(negedge clk);
        expect_st(ST_CUTOFF, RAMP_NONE);
        standstill = 1'b0;
        ctl_model_i.pulse(4'h4);
        ctl_model_i.set_sel(3'h1);
        expect_st(ST_WINDOW, RAMP_NONE);
        repeat (70) @(negedge clk);
        expect_st(ST_LOCK, RAMP_NONE);
        ctl_model_i.pulse(4'h8);
        expect_st(ST_LOCK, RAMP_NONE);
        ctl_model_i.set_sel(3'h5);
        ctl_model_i.set_sel(3'h1);
        expect_st(ST_WINDOW, RAMP_NONE);
        ctl_model_i.pulse(4'h8);
        expect_st(ST_RUN, RAMP_NONE);
        ctl_model_i.pulse(4'h2);
        expect_st(ST_CUTOFF, RAMP_NONE);
        ctl_model_i.restart(3'h0);
        expect_st(ST_RUN, RAMP_NONE);
        nb = n_basic;
        test_src[trig_sel] = 1'b1;
        repeat (6) @(negedge clk);
        `CHK(n_ext, 1)
        `CHK(n_basic, nb + 1)
        `CHK(ext_left > 32'h6, 1'b1)
        `CHK(basic_left > 32'h6, 1'b1)
        `CHK(status[1], 1'b0)
        `CHK(status[31], 1'b0)
        repeat (130) @(negedge clk);
        `CHK(status[1], 1'b1)
        `CHK(status[31], 1'b1)
        `CHK(ext_left, 32'h0)
        expect_st(ST_RUN, RAMP_NONE);
        summarize();
    end

    initial begin
        #200us;
        n_mismatch++;
        summarize();
    end
endmodule : drive_safety_seq_test
